/* File: src/swt_pkg.sv */
// Constants shared by the system watchdog timer
package swt_pkg;
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned TICK_S        = 1;
  localparam int unsigned SEC_CYCLES    = CLK_HZ * TICK_S;
  localparam int unsigned SEC_PER_MIN   = 60;
  localparam int unsigned TIMEOUT_W     = 32;
  localparam int unsigned COUNT_W       = 32;
  localparam int unsigned PRESC_W       = 25;
  localparam int unsigned MIN_W         = 6;
  localparam logic [31:0] SEC_RES_MAX   = 32'h0000_00FF;
  localparam logic [31:0] TIMEOUT_RST   = 32'h0000_0000;
  localparam int unsigned RST_PULSE_CYC = 16;
  localparam int unsigned RST_CNT_W     = 5;

  typedef enum logic [1:0]
  {
    SWT_UNINIT  = 2'b00,
    SWT_IDLE    = 2'b01,
    SWT_RUN     = 2'b10,
    SWT_EXPIRED = 2'b11
  } swt_state_t;
endpackage

/* File: src/swt_watchdog.sv */
// System watchdog countdown timer with command inputs and reset output
// Operation
// - A timeout of 0 to 255 counts that many one-second units.
// - A timeout above 255 counts value/60 plus one minutes.
// - Start begins the countdown from the programmed timeout.
// - Restart reloads the latest programmed timeout and keeps counting.
// - Stop halts the countdown and no reset is raised while stopped.
// - A running countdown that expires raises a whole-system reset.
// - Expiry is signalled on a dedicated hardware reset output.
`timescale 1ns/1ps
module swt_watchdog
  import swt_pkg::*;
#(
  parameter int unsigned SEC_CYC = SEC_CYCLES
)
(
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic                 watchdog_initialize_cmd,
  input  wire logic                 set_timeout_cmd,
  input  wire logic [TIMEOUT_W-1:0] timeout_value,
  input  wire logic                 start_countdown_cmd,
  input  wire logic                 restart_countdown_cmd,
  input  wire logic                 halt_countdown_cmd,
  output logic                      running,
  output logic                      minute_mode,
  output logic [COUNT_W-1:0]        units_left,
  output logic                      system_reset_req
);

  swt_state_t             state_r, state_nxt;
  logic [TIMEOUT_W-1:0]   units_r;
  logic                   minute_r;
  logic [COUNT_W-1:0]     count_r;
  logic [PRESC_W-1:0]     presc_r;
  logic [MIN_W-1:0]       min_r;
  logic [RST_CNT_W-1:0]   rst_cnt_r;

  // Timeout conversion: seconds as given, or minutes as value/60 plus one
  wire                  set_is_min  = timeout_value > SEC_RES_MAX;
  wire [TIMEOUT_W-1:0]  min_units   =
    TIMEOUT_W'(timeout_value / SEC_PER_MIN + 1);
  wire [TIMEOUT_W-1:0]  set_units   =
    set_is_min ? min_units : timeout_value;
  wire                  inited      = state_r != SWT_UNINIT;
  wire                  do_set      = inited && set_timeout_cmd;
  wire                  do_start    = (state_r == SWT_IDLE  // Not mid-pulse
                                      || state_r == SWT_RUN)
                                      && start_countdown_cmd;
  wire                  do_restart  = state_r == SWT_RUN
                                      && restart_countdown_cmd;
  wire                  do_halt     = inited && halt_countdown_cmd;
  // Prescaler tick once a second; minute tick every 60 seconds
  wire                  sec_tick    =
    presc_r == PRESC_W'(SEC_CYC - 1);
  wire                  min_wrap    = min_r == MIN_W'(SEC_PER_MIN - 1);
  wire                  unit_tick   =
    sec_tick && (!minute_r || min_wrap);
  wire                  zero_now    = count_r == '0;
  wire                  expire      = state_r == SWT_RUN && !do_halt
                                      && !do_restart && !do_start
                                      && (zero_now
                                      || (unit_tick
                                      && count_r == COUNT_W'(1)));
  wire                  reload      = do_start || do_restart;

  // Command sequencing; halt outranks restart and start
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SWT_UNINIT:
        if (watchdog_initialize_cmd)
          state_nxt = SWT_IDLE;
      SWT_IDLE:
        if (do_halt)
          state_nxt = SWT_IDLE;
        else if (do_start)
          state_nxt = SWT_RUN;
      SWT_RUN:
        if (do_halt)
          state_nxt = SWT_IDLE;
        else if (expire)
          state_nxt = SWT_EXPIRED;
      SWT_EXPIRED:
        if (rst_cnt_r == RST_CNT_W'(RST_PULSE_CYC - 1))
          state_nxt = SWT_UNINIT;
      default:
        state_nxt = SWT_UNINIT;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      state_r <= SWT_UNINIT;
    else
      state_r <= state_nxt;
  end

  // Programmed timeout, kept across restarts
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      units_r  <= TIMEOUT_RST;
      minute_r <= 1'b0;
    end
    else if (do_set)
    begin
      units_r  <= set_units;
      minute_r <= set_is_min;
    end
  end

  // Prescalers restart with every reload so the first unit is whole
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      presc_r <= '0;
      min_r   <= '0;
    end
    else if (reload || state_r != SWT_RUN)
    begin
      presc_r <= '0;
      min_r   <= '0;
    end
    else if (sec_tick)
    begin
      presc_r <= '0;
      min_r   <= min_wrap ? '0 : min_r + MIN_W'(1);
    end
    else
      presc_r <= presc_r + PRESC_W'(1);
  end

  // Unit countdown; frozen when not running
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      count_r <= '0;
    else if (reload)
      count_r <= units_r;
    else if (state_r == SWT_RUN && unit_tick && !zero_now && !do_halt)
      count_r <= count_r - COUNT_W'(1);
  end

  // Reset pulse length counter; zero time-out expires at once
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rst_cnt_r <= '0;
    else if (state_r == SWT_EXPIRED)
      rst_cnt_r <= rst_cnt_r + RST_CNT_W'(1);
    else
      rst_cnt_r <= '0;
  end

  // Outputs; reset request held a fixed time so downstream logic sees it
  assign system_reset_req = state_r == SWT_EXPIRED;
  assign running          = state_r == SWT_RUN;
  assign minute_mode      = minute_r;
  assign units_left       = count_r;

  a_halt_blocks_reset: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state_r == SWT_IDLE) |=> !system_reset_req)
    else $error("reset raised while stopped");

  a_expire_gives_reset: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    expire |=> system_reset_req)
    else $error("expiry did not raise reset");

  a_reset_pulse_len: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    $rose(system_reset_req) |-> system_reset_req [*8])
    else $error("reset pulse too short");

  a_start_loads: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    do_start && !do_halt |=> running && units_left == $past(units_r))
    else $error("start did not load timeout");

  a_restart_loads: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    do_restart && !do_halt |=> units_left == $past(units_r))
    else $error("restart did not reload");

  a_sec_units: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    do_set && !set_is_min |=> units_r == $past(timeout_value)
    && !minute_mode)
    else $error("second timeout stored wrongly");

  a_min_units: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    do_set && set_is_min |=> minute_mode
    && units_r == $past(timeout_value) / SEC_PER_MIN + 1)
    else $error("minute timeout stored wrongly");

  a_need_init: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    state_r == SWT_UNINIT && !watchdog_initialize_cmd |=> !running)
    else $error("ran without initialise");

  a_count_on_tick: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    running && !unit_tick && !reload |=> units_left == $past(units_left))
    else $error("count moved without unit tick");

  a_halt_stops_run: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    running && do_halt |=> !running && !system_reset_req)
    else $error("stop did not halt countdown");

  a_count_steps: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    running && unit_tick && !reload && !do_halt && !zero_now
    |=> units_left == $past(units_left) - COUNT_W'(1))
    else $error("count missed a unit tick");

  a_reset_pulse_end: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    system_reset_req && rst_cnt_r == RST_CNT_W'(RST_PULSE_CYC - 1)
    |=> !system_reset_req)
    else $error("reset pulse too long");

endmodule

/* File: testbench/swt_host.sv */
// Host software model that issues watchdog commands as one-cycle pulses
`timescale 1ns/1ps
module swt_host
  import swt_pkg::*;
(
  input  wire logic                 clk_sys,
  output logic                      watchdog_initialize_cmd,
  output logic                      set_timeout_cmd,
  output logic [TIMEOUT_W-1:0]      timeout_value,
  output logic                      start_countdown_cmd,
  output logic                      restart_countdown_cmd,
  output logic                      halt_countdown_cmd
);
  logic [4:0] pulse_r = 5'h00;

  // One strobe per command kind, bit order init, set, start, restart, halt
  assign {halt_countdown_cmd, restart_countdown_cmd, start_countdown_cmd,
          set_timeout_cmd, watchdog_initialize_cmd} = pulse_r;
  initial timeout_value = 32'h0000_0000;

  // Launch on the falling edge, then drop the strobe one cycle later
  task automatic cmd(input int k, input logic [TIMEOUT_W-1:0] v);
    @(negedge clk_sys);
    pulse_r = 5'h01 << k;
    timeout_value = v;
    @(negedge clk_sys);
    pulse_r = 5'h00;
    timeout_value = ~v; // Stale value scrambled so no stray sampling hides
  endtask
endmodule

/* File: testbench/swt_watchdog_tb.sv */
// Self-checking bench for the system watchdog timer
`timescale 1ns/1ps
module swt_watchdog_tb
  import swt_pkg::*;
;
  localparam int SC = 10;
  logic clk_sys = 1'b0;
  logic resetn  = 1'b0;
  wire  init_c, set_c, start_c, rst_c, halt_c;
  wire  [TIMEOUT_W-1:0] tv;
  logic running, minute_mode, system_reset_req;
  logic [COUNT_W-1:0] units_left;
  int   n_errors = 0;
  int   cmp_count = 0;
  int   n, m;
  logic seen;
  logic [31:0] r_val[5] = '{32'h3, 32'hFF, 32'h100, 32'h190, 32'h3C};
  logic [31:0] r_exp[5] = '{32'h3, 32'hFF, 32'h5, 32'h7, 32'h3C};
  logic        r_min[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  always #20 clk_sys = ~clk_sys;

  swt_host swt_host_inst (.clk_sys(clk_sys), .watchdog_initialize_cmd(init_c),
    .set_timeout_cmd(set_c), .timeout_value(tv),
    .start_countdown_cmd(start_c), .restart_countdown_cmd(rst_c),
    .halt_countdown_cmd(halt_c));

  swt_watchdog #(.SEC_CYC(SC)) swt_watchdog_inst (.clk_sys(clk_sys),
    .resetn(resetn), .watchdog_initialize_cmd(init_c),
    .set_timeout_cmd(set_c), .timeout_value(tv),
    .start_countdown_cmd(start_c), .restart_countdown_cmd(rst_c),
    .halt_countdown_cmd(halt_c), .running(running),
    .minute_mode(minute_mode), .units_left(units_left),
    .system_reset_req(system_reset_req));

  // Compare a multi-bit value
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %0t value got %0h expected %0h", $time, g, e);
    end
  endtask

  // Compare a single flag
  task automatic chk_b(input logic g, input logic e);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %0t flag got %b expected %b", $time, g, e);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask

  // Start a countdown from a freshly initialised state
  task automatic arm(input logic [31:0] v);
    swt_host_inst.cmd(0, 32'h0);
    swt_host_inst.cmd(1, v);
    swt_host_inst.cmd(2, 32'h0);
    cyc(1);
  endtask

  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog sized well above the roughly 1000 cycles the tests need
  initial
  begin
    #400000;
    n_errors++;
    finish_test();
  end

  initial
  begin
    // Table rows: resolution choice and loaded unit count
    cyc(12);
    resetn = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      arm(r_val[i]);
      chk(units_left, r_exp[i]);
      chk_b(minute_mode, r_min[i]);
      chk_b(running, 1'b1);
      swt_host_inst.cmd(4, 32'h0);
      chk_b(running, 1'b0);
    end
    $display("test rows done");
    // Minute units step only every sixty seconds
    arm(32'h190);
    cyc(SC * SEC_PER_MIN - 40);
    chk(units_left, 32'h7);
    cyc(60);
    chk(units_left, 32'h6);
    swt_host_inst.cmd(4, 32'h0);
    $display("test minute done");
    // Expiry timing and reset pulse width
    arm(32'h3);
    n = 0;
    while (system_reset_req !== 1'b1 && n < 40)
    begin
      cyc(1);
      n++;
    end
    chk_b((n >= 26) && (n <= 32), 1'b1);
    m = 0;
    while (system_reset_req === 1'b1 && m < 40)
    begin
      chk_b(running, 1'b0);
      cyc(1);
      m++;
    end
    chk(m, RST_PULSE_CYC);
    $display("test expiry done");
    // Restart reloads, then halt keeps reset quiet
    arm(32'h3);
    cyc(15);
    chk(units_left, 32'h2);
    swt_host_inst.cmd(3, 32'h0);
    chk(units_left, 32'h3);
    cyc(25);
    chk_b(system_reset_req, 1'b0);
    swt_host_inst.cmd(4, 32'h0);
    seen = 1'b0;
    repeat (60)
    begin
      cyc(1);
      seen = seen | (system_reset_req !== 1'b0);
    end
    chk_b(seen, 1'b0);
    $display("test restart halt done");
    // Zero timeout expires right after start
    arm(32'h0);
    chk_b(system_reset_req, 1'b1);
    $display("test zero done");
    // Reset in mid-pulse clears all; later commands wait for initialise
    swt_host_inst.cmd(1, 32'h190);
    chk_b(minute_mode, 1'b1);
    resetn = 1'b0;
    cyc(2);
    chk_b(system_reset_req, 1'b0);
    chk_b(running, 1'b0);
    chk_b(minute_mode, 1'b0);
    chk(units_left, 32'h0);
    resetn = 1'b1;
    swt_host_inst.cmd(1, 32'h190);
    swt_host_inst.cmd(2, 32'h0);
    cyc(1);
    chk_b(running, 1'b0);
    chk_b(minute_mode, 1'b0);
    chk(units_left, 32'h0);
    $display("test reset done");
    finish_test();
  end
endmodule
